// ===== src/tcmr_pkg.sv
// What this block does
// - Force strobe B gives immediate match, non-PWM
// - Forced B effect follows channel B action
// - Forced B match: no interrupt, no clear
// - Force B bit is strobe, reads zero
// - Force strobe C gives immediate match, non-PWM
// - Forced C effect uses action at strobe
// - Forced C match: no interrupt, no clear
// - Force C bit self-clears, reads zero
// - Low five control bits reserved, unwritable
// - Counter visible as readable writable byte pair
// - Counter bytes move atomically through latch
// - One shared high-byte latch for all
// - Counter write blocks next tick's matches
// - Three compares checked every unblocked timer tick
// - Compare writes staged, land together on low
// - Non-PWM modes are codes 0, 4, C
// - Match pulse cycle after equality, never forced
// - No pins; events stay internal
package tcmr_pkg;
  localparam logic [15:0] TCMR_ADDR_FORCE_CTRL = 16'h0122;
  localparam logic [15:0] TCMR_ADDR_COUNT_LOW = 16'h0124;
  localparam logic [15:0] TCMR_ADDR_COUNT_HIGH = 16'h0125;
  localparam logic [15:0] TCMR_ADDR_CMP_A_LOW = 16'h0128;
  localparam logic [15:0] TCMR_ADDR_CMP_A_HIGH = 16'h0129;
  localparam logic [15:0] TCMR_ADDR_CMP_B_LOW = 16'h012A;
  localparam logic [15:0] TCMR_ADDR_CMP_B_HIGH = 16'h012B;
  localparam logic [15:0] TCMR_ADDR_CMP_C_LOW = 16'h012C;
  localparam logic [15:0] TCMR_ADDR_CMP_C_HIGH = 16'h012D;
  localparam int TCMR_NUM_CHAN = 3;
  localparam int TCMR_CHAN_A = 0;
  localparam int TCMR_CHAN_B = 1;
  localparam int TCMR_CHAN_C = 2;
  localparam int TCMR_FORCE_B_BIT = 6;
  localparam int TCMR_FORCE_C_BIT = 5;
  localparam logic [7:0] TCMR_FORCE_CTRL_READ = 8'h00;
  localparam logic [7:0] TCMR_CMP_C_LOW_WMASK = 8'h7F;
  localparam logic [7:0] TCMR_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] TCMR_BYTE_RESET = 8'h00;
  localparam logic [15:0] TCMR_WORD_RESET = 16'h0000;
  localparam logic [15:0] TCMR_COUNT_STEP = 16'h0001;
  localparam logic [1:0] TCMR_ACTION_RESET = 2'h0;
  localparam logic [3:0] TCMR_MODE_NORMAL = 4'h0;
  localparam logic [3:0] TCMR_MODE_CLEAR_ON_MATCH = 4'h4;
  localparam logic [3:0] TCMR_MODE_CLEAR_ON_MATCH_ALT = 4'hC;

  typedef struct packed {
    logic [7:0] temp;
    logic [15:0] count;
    logic [TCMR_NUM_CHAN-1:0][15:0] compare;
    logic block_pending;
    logic [7:0] rdata;
  } tcmr_main_state_t;

  typedef struct packed {
    logic event_pulse;
    logic [1:0] action;
  } tcmr_force_state_t;

  typedef struct packed {
    logic match;
  } tcmr_chan_state_t;

  function automatic logic tcmr_is_non_pwm(input logic [3:0] mode);
    tcmr_is_non_pwm = (mode == TCMR_MODE_NORMAL) || (mode == TCMR_MODE_CLEAR_ON_MATCH)
      || (mode == TCMR_MODE_CLEAR_ON_MATCH_ALT);
  endfunction

  function automatic logic tcmr_is_clear_on_match(input logic [3:0] mode);
    tcmr_is_clear_on_match = (mode == TCMR_MODE_CLEAR_ON_MATCH)
      || (mode == TCMR_MODE_CLEAR_ON_MATCH_ALT);
  endfunction
endpackage

// ===== src/tcmr_cmp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tcmr_cmp_if;
  logic [15:0] count;
  logic [15:0] compare;
  logic tick;
  logic block;
  logic match;
  modport ctrl (output count, output compare, output tick, output block, input match);
  modport chan (input count, input compare, input tick, input block, output match);
endinterface
`default_nettype wire

// ===== src/tcmr_cmp_chan.sv
`timescale 1ns/100ps
`default_nettype none
module tcmr_cmp_chan
  import tcmr_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_reset_n, // Synchronous reset, active low
  tcmr_cmp_if.chan cmp // Counter view and match pulse
);
  tcmr_chan_state_t state;
  tcmr_chan_state_t next_state;

  always_comb
  begin
    next_state = state;
    // Pulse lands the cycle after the tick that saw equality
    next_state.match = cmp.tick && !cmp.block && (cmp.count == cmp.compare);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign cmp.match = state.match;
endmodule // tcmr_cmp_chan
`default_nettype wire

// ===== src/tcmr_force_unit.sv
`timescale 1ns/100ps
`default_nettype none
module tcmr_force_unit
  import tcmr_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic i_strobe, // One written to this channel's force bit
  input wire logic [3:0] i_waveform_mode_field, // Current waveform mode
  input wire logic [1:0] i_output_action, // Channel compare output action
  output logic o_event, // Forced match pulse
  output logic [1:0] o_action // Action sampled at the strobe
);
  tcmr_force_state_t state;
  tcmr_force_state_t next_state;

  always_comb
  begin
    next_state = state;
    next_state.event_pulse = i_strobe && tcmr_is_non_pwm(i_waveform_mode_field);
    // Action is frozen at the strobe so a later field change cannot alter it
    if (next_state.event_pulse)
      next_state.action = i_output_action;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      state.event_pulse <= 1'b0;
      state.action <= TCMR_ACTION_RESET;
    end
    else
      state <= next_state;
  end

  assign o_event = state.event_pulse;
  assign o_action = state.action;

  property p_force_gate;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_event |-> $past(i_strobe) && tcmr_is_non_pwm($past(i_waveform_mode_field));
  endproperty
  a_force_gate: assert property (p_force_gate)
    else $error("forced match outside a non-PWM mode");

  property p_force_action;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_event |-> (o_action == $past(i_output_action))
      ##1 (o_event || (o_action == $past(o_action)));
  endproperty
  a_force_action: assert property (p_force_action)
    else $error("forced action not taken from strobe cycle");
endmodule // tcmr_force_unit
`default_nettype wire

// ===== src/tcmr_timer_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tcmr_timer_regs
  import tcmr_pkg::*;
(
  input wire logic i_clk_sys, // System clock, 10 MHz
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic [15:0] i_addr, // Data-space byte address
  input wire logic i_wr_en, // Byte write strobe
  input wire logic i_rd_en, // Byte read strobe
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_timer_tick, // Prescaled timer clock enable
  input wire logic [3:0] i_waveform_mode_field, // Waveform mode from control
  input wire logic [1:0] i_chan_b_output_action, // Channel B output action
  input wire logic [1:0] i_chan_c_output_action, // Channel C output action
  output logic [7:0] o_rdata, // Read data, one cycle after the read
  output logic [15:0] o_count_value, // Current counter
  output logic [2:0] o_match_set, // Match flag set pulses, A..C
  output logic o_force_event_b, // Forced match pulse, channel B
  output logic o_force_event_c, // Forced match pulse, channel C
  output logic [1:0] o_force_action_b, // Action of last forced B match
  output logic [1:0] o_force_action_c // Action of last forced C match
);
  tcmr_main_state_t state;
  tcmr_main_state_t next_state;
  logic [TCMR_NUM_CHAN-1:0] match;
  logic wr_force;
  logic wr_count;
  logic ctc_clear;
  logic [7:0] rd_mux;

  tcmr_cmp_if cmp_bus[TCMR_NUM_CHAN]();

  genvar g;
  generate
    for (g = 0; g < TCMR_NUM_CHAN; g++)
    begin : g_chan
      assign cmp_bus[g].count = state.count;
      assign cmp_bus[g].compare = state.compare[g];
      assign cmp_bus[g].tick = i_timer_tick;
      assign cmp_bus[g].block = state.block_pending;
      assign match[g] = cmp_bus[g].match;
      tcmr_cmp_chan u_chan (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .cmp(cmp_bus[g])
      );
    end
  endgenerate

  // Force strobes never reach the match pulses or the counter clear
  assign wr_force = i_wr_en && (i_addr == TCMR_ADDR_FORCE_CTRL);

  tcmr_force_unit u_force_b (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_strobe(wr_force && i_wdata[TCMR_FORCE_B_BIT]),
    .i_waveform_mode_field(i_waveform_mode_field),
    .i_output_action(i_chan_b_output_action),
    .o_event(o_force_event_b),
    .o_action(o_force_action_b)
  );

  tcmr_force_unit u_force_c (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_strobe(wr_force && i_wdata[TCMR_FORCE_C_BIT]),
    .i_waveform_mode_field(i_waveform_mode_field),
    .i_output_action(i_chan_c_output_action),
    .o_event(o_force_event_c),
    .o_action(o_force_action_c)
  );

  assign wr_count = i_wr_en && ((i_addr == TCMR_ADDR_COUNT_LOW)
    || (i_addr == TCMR_ADDR_COUNT_HIGH));

  // Clear-on-match uses compare A only; a blocked tick cannot clear either
  assign ctc_clear = i_timer_tick && !state.block_pending
    && tcmr_is_clear_on_match(i_waveform_mode_field)
    && (state.count == state.compare[TCMR_CHAN_A]);

  always_comb
  begin
    rd_mux = TCMR_UNMAPPED_READ;
    case (i_addr)
      TCMR_ADDR_FORCE_CTRL: rd_mux = TCMR_FORCE_CTRL_READ;
      TCMR_ADDR_COUNT_LOW: rd_mux = state.count[7:0];
      TCMR_ADDR_COUNT_HIGH: rd_mux = state.temp;
      TCMR_ADDR_CMP_A_LOW: rd_mux = state.compare[TCMR_CHAN_A][7:0];
      TCMR_ADDR_CMP_A_HIGH: rd_mux = state.compare[TCMR_CHAN_A][15:8];
      TCMR_ADDR_CMP_B_LOW: rd_mux = state.compare[TCMR_CHAN_B][7:0];
      TCMR_ADDR_CMP_B_HIGH: rd_mux = state.compare[TCMR_CHAN_B][15:8];
      TCMR_ADDR_CMP_C_LOW: rd_mux = state.compare[TCMR_CHAN_C][7:0];
      TCMR_ADDR_CMP_C_HIGH: rd_mux = state.compare[TCMR_CHAN_C][15:8];
      default: rd_mux = TCMR_UNMAPPED_READ;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_state.rdata = i_rd_en ? rd_mux : state.rdata;

    // Counter advances on the tick; a CPU write below takes priority
    if (ctc_clear)
      next_state.count = TCMR_WORD_RESET;
    else if (i_timer_tick)
      next_state.count = state.count + TCMR_COUNT_STEP;

    // A pending block is used up by the first tick after the write
    if (i_timer_tick)
      next_state.block_pending = 1'b0;

    // Reading the low byte snapshots the high byte into the shared latch
    if (i_rd_en && (i_addr == TCMR_ADDR_COUNT_LOW))
      next_state.temp = state.count[15:8];

    if (i_wr_en)
    begin
      case (i_addr)
        TCMR_ADDR_COUNT_HIGH,
        TCMR_ADDR_CMP_A_HIGH,
        TCMR_ADDR_CMP_B_HIGH,
        TCMR_ADDR_CMP_C_HIGH: next_state.temp = i_wdata;
        TCMR_ADDR_COUNT_LOW:
        begin
          next_state.count = {state.temp, i_wdata};
        end
        TCMR_ADDR_CMP_A_LOW: next_state.compare[TCMR_CHAN_A] = {state.temp, i_wdata};
        TCMR_ADDR_CMP_B_LOW: next_state.compare[TCMR_CHAN_B] = {state.temp, i_wdata};
        TCMR_ADDR_CMP_C_LOW:
        begin
          // Top bit of this low byte is read-only and holds its value
          next_state.compare[TCMR_CHAN_C] = {state.temp,
            (i_wdata & TCMR_CMP_C_LOW_WMASK)
            | (state.compare[TCMR_CHAN_C][7:0] & ~TCMR_CMP_C_LOW_WMASK)};
        end
        default: next_state.temp = state.temp;
      endcase
    end

    // Set after the tick clear so a write in a tick cycle still blocks the next one
    if (wr_count)
      next_state.block_pending = 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      state.temp <= TCMR_BYTE_RESET;
      state.count <= TCMR_WORD_RESET;
      state.compare <= '0;
      state.block_pending <= 1'b0;
      state.rdata <= TCMR_BYTE_RESET;
    end
    else
      state <= next_state;
  end

  assign o_rdata = state.rdata;
  assign o_count_value = state.count;
  assign o_match_set = match;

  property p_force_b_fires;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_force && i_wdata[TCMR_FORCE_B_BIT] && tcmr_is_non_pwm(i_waveform_mode_field)
      |=> o_force_event_b
      ##1 (!o_force_event_b || $past(wr_force && i_wdata[TCMR_FORCE_B_BIT]));
  endproperty
  a_force_b_fires: assert property (p_force_b_fires)
    else $error("force B strobe did not give one forced match");

  property p_force_c_pwm_quiet;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    !tcmr_is_non_pwm(i_waveform_mode_field) |=> !o_force_event_c;
  endproperty
  a_force_c_pwm_quiet: assert property (p_force_c_pwm_quiet)
    else $error("force C acted in a PWM mode");

  property p_force_no_clear;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_force && !i_timer_tick && !wr_count |=> o_count_value == $past(o_count_value);
  endproperty
  a_force_no_clear: assert property (p_force_no_clear)
    else $error("force strobe disturbed the counter");

  property p_force_reads_zero;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_rd_en && (i_addr == TCMR_ADDR_FORCE_CTRL) |=> o_rdata == TCMR_FORCE_CTRL_READ;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("force control register read non-zero");

  property p_count_atomic_read;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_rd_en && (i_addr == TCMR_ADDR_COUNT_LOW) && !i_wr_en
      ##1 i_rd_en && (i_addr == TCMR_ADDR_COUNT_HIGH) && !i_wr_en
      |=> {o_rdata, $past(o_rdata)} == $past(o_count_value, 2);
  endproperty
  a_count_atomic_read: assert property (p_count_atomic_read)
    else $error("counter bytes not read as one word");

  property p_write_blocks_match;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_count ##1 (!i_timer_tick && !wr_count) ##1 i_timer_tick |=> o_match_set == 3'b000;
  endproperty
  a_write_blocks_match: assert property (p_write_blocks_match)
    else $error("match seen on the tick after a counter write");

  property p_match_cause;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_match_set[TCMR_CHAN_B] |-> $past(i_timer_tick)
      && ($past(o_count_value) == $past(state.compare[TCMR_CHAN_B]));
  endproperty
  a_match_cause: assert property (p_match_cause)
    else $error("channel B match without equality on a tick");

  property p_cmp_staged_write;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_wr_en && (i_addr == TCMR_ADDR_CMP_B_HIGH)
      ##1 i_wr_en && (i_addr == TCMR_ADDR_CMP_B_LOW)
      |=> state.compare[TCMR_CHAN_B] == {$past(i_wdata, 2), $past(i_wdata)};
  endproperty
  a_cmp_staged_write: assert property (p_cmp_staged_write)
    else $error("compare B bytes not written together");

  property p_reset_zero;
    @(posedge i_clk_sys)
    !i_reset_n |=> (o_count_value == TCMR_WORD_RESET) && (state.temp == TCMR_BYTE_RESET)
      && (o_match_set == 3'b000);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("state not cleared by reset");
endmodule // tcmr_timer_regs
`default_nettype wire

// ===== bench/tcmr_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module tcmr_cpu_model
  import tcmr_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  input wire logic [7:0] i_rdata, // Read data from the block
  output logic [15:0] o_addr, // Byte address
  output logic o_wr_en, // Write strobe
  output logic o_rd_en, // Read strobe
  output logic [7:0] o_wdata // Write data
);
  initial
  begin
    o_addr = 16'h0000;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_wdata = 8'h00;
  end

  // Idle bus shows inverted values so nothing can lean on a stale address
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(negedge i_clk_sys);
    o_addr = addr;
    o_wdata = data;
    o_wr_en = 1'b1;
    @(negedge i_clk_sys);
    o_wr_en = 1'b0;
    o_addr = ~addr;
    o_wdata = ~data;
  endtask

  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    @(negedge i_clk_sys);
    o_addr = addr;
    o_rd_en = 1'b1;
    @(negedge i_clk_sys);
    o_rd_en = 1'b0;
    data = i_rdata;
    o_addr = ~addr;
  endtask

  // High byte goes first so the low byte lands the whole word; bytes go back to back
  task automatic wr16(input logic [15:0] hi_addr, input logic [15:0] value);
    @(negedge i_clk_sys);
    o_addr = hi_addr;
    o_wdata = value[15:8];
    o_wr_en = 1'b1;
    @(negedge i_clk_sys);
    o_addr = hi_addr - 16'h0001;
    o_wdata = value[7:0];
    @(negedge i_clk_sys);
    o_wr_en = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask

  // Low byte first latches the high byte; both reads back to back
  task automatic rd16(input logic [15:0] lo_addr, output logic [15:0] value);
    @(negedge i_clk_sys);
    o_addr = lo_addr;
    o_rd_en = 1'b1;
    @(negedge i_clk_sys);
    value[7:0] = i_rdata;
    o_addr = lo_addr + 16'h0001;
    @(negedge i_clk_sys);
    o_rd_en = 1'b0;
    value[15:8] = i_rdata;
    o_addr = ~o_addr;
  endtask
endmodule // tcmr_cpu_model
`default_nettype wire

// ===== bench/tb_tcmr_timer_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_tcmr_timer_regs;
  import tcmr_pkg::*;
  logic i_clk_sys;
  logic i_reset_n;
  logic [15:0] addr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic tick;
  logic [3:0] mode;
  logic [1:0] act_b;
  logic [1:0] act_c;
  logic [15:0] count;
  logic [2:0] match_set;
  logic ev_b;
  logic ev_c;
  logic [1:0] fa_b;
  logic [1:0] fa_c;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  tcmr_timer_regs i_tcmr_timer_regs (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_addr(addr), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_wdata(wdata), .i_timer_tick(tick),
    .i_waveform_mode_field(mode), .i_chan_b_output_action(act_b),
    .i_chan_c_output_action(act_c), .o_rdata(rdata), .o_count_value(count),
    .o_match_set(match_set), .o_force_event_b(ev_b), .o_force_event_c(ev_c),
    .o_force_action_b(fa_b), .o_force_action_c(fa_c));
  tcmr_cpu_model i_tcmr_cpu_model (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_addr(addr),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_wdata(wdata));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The whole run needs well under two thousand cycles
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_tcmr_cpu_model.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  task automatic pulse_tick();
    @(negedge i_clk_sys);
    tick = 1'b1;
    @(negedge i_clk_sys);
    tick = 1'b0;
  endtask

  task automatic test_reset();
    logic [15:0] a [10] = '{TCMR_ADDR_COUNT_HIGH, TCMR_ADDR_FORCE_CTRL, TCMR_ADDR_COUNT_LOW,
      TCMR_ADDR_CMP_A_LOW, TCMR_ADDR_CMP_A_HIGH, TCMR_ADDR_CMP_B_LOW, TCMR_ADDR_CMP_B_HIGH,
      TCMR_ADDR_CMP_C_LOW, TCMR_ADDR_CMP_C_HIGH, 16'h0126};
    // Latch is loaded, then reset pulsed, so a mid-run reset must clear loaded state
    i_tcmr_cpu_model.wr(TCMR_ADDR_CMP_B_HIGH, 8'hA5);
    @(negedge i_clk_sys);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    foreach (a[k]) rd_chk(a[k], 8'h00);
    chk(count, 16'h0000);
    chk({12'h000, fa_b, fa_c}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic test_compare();
    i_tcmr_cpu_model.wr16(TCMR_ADDR_CMP_B_HIGH, 16'h1234);
    rd_chk(TCMR_ADDR_CMP_B_HIGH, 8'h12);
    rd_chk(TCMR_ADDR_CMP_B_LOW, 8'h34);
    i_tcmr_cpu_model.wr16(TCMR_ADDR_CMP_C_HIGH, 16'hABFF);
    rd_chk(TCMR_ADDR_CMP_C_LOW, 8'h7F);
    i_tcmr_cpu_model.wr(TCMR_ADDR_CMP_A_HIGH, 8'h56);
    i_tcmr_cpu_model.wr(TCMR_ADDR_CMP_B_HIGH, 8'h9A);
    rd_chk(TCMR_ADDR_CMP_B_HIGH, 8'h12);
    i_tcmr_cpu_model.wr(TCMR_ADDR_CMP_A_LOW, 8'h78);
    rd_chk(TCMR_ADDR_CMP_A_HIGH, 8'h9A);
    i_tcmr_cpu_model.wr(16'h0126, 8'hFF);
    rd_chk(16'h0126, 8'h00);
    $display("test compare done");
  endtask

  task automatic test_count_read();
    logic [15:0] v;
    i_tcmr_cpu_model.wr16(TCMR_ADDR_COUNT_HIGH, 16'h12FF);
    chk(count, 16'h12FF);
    rd_chk(TCMR_ADDR_COUNT_LOW, 8'hFF);
    pulse_tick();
    rd_chk(TCMR_ADDR_COUNT_HIGH, 8'h12);
    chk(count, 16'h1300);
    i_tcmr_cpu_model.rd16(TCMR_ADDR_COUNT_LOW, v);
    chk(v, 16'h1300);
    $display("test count read done");
  endtask

  task automatic test_match();
    mode = TCMR_MODE_NORMAL;
    i_tcmr_cpu_model.wr16(TCMR_ADDR_CMP_A_HIGH, 16'h0005);
    i_tcmr_cpu_model.wr16(TCMR_ADDR_CMP_B_HIGH, 16'h0006);
    i_tcmr_cpu_model.wr16(TCMR_ADDR_CMP_C_HIGH, 16'h0007);
    i_tcmr_cpu_model.wr16(TCMR_ADDR_COUNT_HIGH, 16'h0005);
    pulse_tick();
    chk({13'h0000, match_set}, 16'h0000);
    pulse_tick();
    chk({13'h0000, match_set}, 16'h0002);
    pulse_tick();
    chk({13'h0000, match_set}, 16'h0004);
    pulse_tick();
    chk({13'h0000, match_set}, 16'h0000);
    chk(count, 16'h0009);
    $display("test match done");
  endtask

  task automatic test_clear_on_match();
    logic [3:0] m [2] = '{TCMR_MODE_CLEAR_ON_MATCH, TCMR_MODE_CLEAR_ON_MATCH_ALT};
    foreach (m[k])
    begin
      mode = m[k];
      i_tcmr_cpu_model.wr16(TCMR_ADDR_CMP_A_HIGH, 16'h0005);
      // Count equals top here, but the write blocks both the match and the clear
      i_tcmr_cpu_model.wr16(TCMR_ADDR_COUNT_HIGH, 16'h0005);
      pulse_tick();
      chk(count, 16'h0006);
      chk({13'h0000, match_set}, 16'h0000);
      i_tcmr_cpu_model.wr16(TCMR_ADDR_CMP_A_HIGH, 16'h0006);
      pulse_tick();
      chk(count, 16'h0000);
      chk({13'h0000, match_set}, 16'h0003);
    end
    $display("test clear on match done");
  endtask

  task automatic test_force();
    logic [3:0] m [5] = '{4'h0, 4'h4, 4'hC, 4'h1, 4'hF};
    logic [1:0] eb;
    logic [1:0] ec;
    logic [15:0] c0;
    c0 = count;
    foreach (m[k])
    begin
      mode = m[k];
      act_b = 2'(k);
      act_c = 2'(3 - k);
      if (k < 3)
      begin
        eb = act_b;
        ec = act_c;
      end
      i_tcmr_cpu_model.wr(TCMR_ADDR_FORCE_CTRL, 8'h60);
      chk({15'h0000, ev_b}, {15'h0000, k < 3});
      chk({15'h0000, ev_c}, {15'h0000, k < 3});
      act_b = ~act_b;
      act_c = ~act_c;
      chk({14'h0000, fa_b}, {14'h0000, eb});
      chk({14'h0000, fa_c}, {14'h0000, ec});
      chk({13'h0000, match_set}, 16'h0000);
      chk(count, c0);
      @(negedge i_clk_sys);
      chk({14'h0000, ev_b, ev_c}, 16'h0000);
    end
    mode = TCMR_MODE_NORMAL;
    i_tcmr_cpu_model.wr(TCMR_ADDR_FORCE_CTRL, 8'h9F);
    chk({14'h0000, ev_b, ev_c}, 16'h0000);
    rd_chk(TCMR_ADDR_FORCE_CTRL, 8'h00);
    $display("test force done");
  endtask

  initial
  begin
    i_reset_n = 1'b0;
    tick = 1'b0;
    mode = TCMR_MODE_NORMAL;
    act_b = 2'h0;
    act_c = 2'h0;
    repeat (10) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    test_reset();
    test_compare();
    test_count_read();
    test_match();
    test_clear_on_match();
    test_force();
    test_reset();
    summarize();
  end
endmodule // tb_tcmr_timer_regs
`default_nettype wire
